// ### src/dtsl_top.sv
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "dtsl_defs.svh"
module dtsl_top
  import dtsl_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Comparator results, same clock
  input  wire logic        cmp_a_match,
  input  wire logic        cmp_b_match,
  input  wire logic        cmp_a_exec,
  input  wire logic        cmp_b_exec,
  input  wire logic        addr_lt_a,
  input  wire logic        addr_gt_b,
  input  wire logic [15:0] capture_data,
  input  wire logic        capture_valid,
  input  wire logic [15:0] fifo_word,
  // FIFO control
  output logic             fifo_store,
  output logic [15:0]      fifo_store_data,
  output logic             trigger_event,
  output logic             run_active
);
  // ****************************************
  // Bus decode
  // ****************************************
  logic        wr_en;
  logic        rd_en;
  logic        map_hit;
  logic [7:0]  ctrl_q;
  logic [7:0]  trig_q;
  logic        af_q;
  logic        bf_q;
  logic        runf_q;
  logic [3:0]  cnt_q;
  logic        store_on_q;
  dtsl_seq_e   seq_q;
  logic        trig_hit;
  logic        ev_mode;
  logic        begin_trace;
  logic        run_start;
  logic        run_done;
  logic        sw_stop;
  logic        fifo_full;
  logic        store_now;

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign map_hit = (paddr == `DTSL_ADDR_CTRL) | (paddr == `DTSL_ADDR_TRIG)
                 | (paddr == `DTSL_ADDR_STAT) | (paddr == `DTSL_ADDR_FIFOH);
  assign pready  = 1'b1;
  // Either direction flags an unmapped offset
  assign pslverr = (wr_en | rd_en) & ~map_hit;

  function automatic logic is_event_mode(input logic [3:0] m);
    is_event_mode = (m == 4'(DTSL_M_EV_B)) | (m == 4'(DTSL_M_A_THEN_EV_B));
  endfunction

  // ****************************************
  // Comparator qualification
  // ****************************************
  dtsl_cmp_if cmp_if ();
  assign cmp_if.match_a  = cmp_a_match;
  assign cmp_if.match_b  = cmp_b_match;
  assign cmp_if.exec_a   = cmp_a_exec;
  assign cmp_if.exec_b   = cmp_b_exec;
  assign cmp_if.qual_sel = trig_q[`DTSL_TRIG_QUAL];

  dtsl_qualify u_qual (
    .cmp (cmp_if.qual)
  );

  // ****************************************
  // Control register
  // ****************************************
  // Write of 0 to run or enable bit stops a run
  assign run_start = wr_en & (paddr == `DTSL_ADDR_CTRL) & pwdata[`DTSL_CTRL_ON]
                   & pwdata[`DTSL_CTRL_RUN] & ~runf_q;
  assign sw_stop   = wr_en & (paddr == `DTSL_ADDR_CTRL)
                   & (~pwdata[`DTSL_CTRL_ON] | ~pwdata[`DTSL_CTRL_RUN]); // [RULE16]

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= `DTSL_CTRL_RST;
    end else if (wr_en && paddr == `DTSL_ADDR_CTRL) begin
      ctrl_q <= pwdata[7:0];
    end else if (run_done) begin
      ctrl_q[`DTSL_CTRL_RUN] <= 1'b0; // [RULE21]
    end
  end

  // Trigger setup locked during a run
  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_q <= `DTSL_TRIG_RST;
    end else if (wr_en && paddr == `DTSL_ADDR_TRIG && !ctrl_q[`DTSL_CTRL_RUN]) begin
      trig_q <= pwdata[7:0] & `DTSL_TRIG_MASK; // [RULE1] [RULE22]
    end
  end

  // ****************************************
  // Trigger mode decode
  // ****************************************
  assign ev_mode     = is_event_mode(trig_q[3:0]);
  assign begin_trace = ev_mode | trig_q[`DTSL_TRIG_BEGIN]; // [RULE5]

  always_comb begin
    trig_hit = 1'b0;
    unique case (trig_q[3:0])
      4'(DTSL_M_A_ONLY):      trig_hit = cmp_if.hit_a;                  // [RULE6]
      4'(DTSL_M_A_OR_B):      trig_hit = cmp_if.hit_a | cmp_if.hit_b;   // [RULE6]
      4'(DTSL_M_A_THEN_B):    trig_hit = (seq_q == DTSL_ARMED) & cmp_if.hit_b; // [RULE6]
      4'(DTSL_M_EV_B):        trig_hit = cmp_if.hit_b;                  // [RULE7]
      4'(DTSL_M_A_THEN_EV_B): trig_hit = (seq_q == DTSL_ARMED) & cmp_if.hit_b; // [RULE7]
      4'(DTSL_M_A_AND_B):     trig_hit = cmp_if.hit_a & cmp_if.hit_b;   // [RULE8]
      4'(DTSL_M_A_AND_NOT_B): trig_hit = cmp_if.hit_a & ~cmp_if.hit_b;  // [RULE8]
      4'(DTSL_M_INSIDE):      trig_hit = cmp_if.hit_a & ~addr_lt_a & ~addr_gt_b; // [RULE9]
      4'(DTSL_M_OUTSIDE):     trig_hit = cmp_if.hit_a & (addr_lt_a | addr_gt_b); // [RULE9]
      default:                trig_hit = 1'b0;                          // [RULE10]
    endcase
  end

  assign trigger_event = runf_q & trig_hit;

  // A-then-B sequencing
  always_ff @(posedge mclk) begin
    if (rst) begin
      seq_q <= DTSL_IDLE;
    end else if (run_start) begin
      seq_q <= DTSL_WAIT_A;
    end else if (!runf_q) begin
      seq_q <= DTSL_IDLE;
    end else if (seq_q == DTSL_WAIT_A && cmp_if.hit_a) begin
      seq_q <= DTSL_ARMED; // [RULE6] [RULE7]
    end
  end

  // ****************************************
  // Capture and run end
  // ****************************************
  assign fifo_full = (cnt_q == `DTSL_FIFO_DEPTH);
  // Event modes store on each event; end-trace modes store on each capture strobe, begin-trace modes only after the trigger
  assign store_now = runf_q & (ev_mode ? trigger_event
                   : (capture_valid & (store_on_q | ~begin_trace))); // [RULE4]
  // Strobe leaves on a flop so it meets the word it stores
  always_ff @(posedge mclk) begin
    if (rst) begin
      fifo_store <= 1'b0;
    end else begin
      fifo_store <= store_now; // [RULE4]
    end
  end
  assign run_done  = runf_q & ((begin_trace & fifo_full)
                   | (~begin_trace & trigger_event)); // [RULE15]

  always_ff @(posedge mclk) begin
    if (rst) begin
      fifo_store_data <= 16'h0000;
    end else begin
      fifo_store_data <= ev_mode ? {8'h00, capture_data[7:0]} : capture_data; // [RULE20]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      store_on_q <= 1'b0;
    end else if (run_start) begin
      store_on_q <= 1'b0;
    end else if (trigger_event && begin_trace) begin
      store_on_q <= 1'b1; // [RULE4]
    end
  end

  // Count saturates at depth; stores in circular fill past eight leave it at eight
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else if (run_start) begin
      cnt_q <= 4'h0; // [RULE17]
    end else if (store_now && !fifo_full) begin
      cnt_q <= cnt_q + 4'h1; // [RULE17] [RULE18]
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      runf_q <= 1'b0;
    end else if (run_start) begin
      runf_q <= 1'b1; // [RULE14] [RULE21]
    end else if (run_done || sw_stop) begin
      runf_q <= 1'b0; // [RULE15] [RULE16]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      af_q <= 1'b0;
    end else if (run_start) begin
      af_q <= 1'b0; // [RULE12]
    end else if (runf_q && cmp_if.hit_a) begin
      af_q <= 1'b1; // [RULE12]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bf_q <= 1'b0;
    end else if (run_start) begin
      bf_q <= 1'b0; // [RULE13]
    end else if (runf_q && cmp_if.hit_b) begin
      bf_q <= 1'b1; // [RULE13]
    end
  end

  assign run_active = runf_q;

  // ****************************************
  // Read data
  // ****************************************
  // Status writes fall through with no effect
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `DTSL_ADDR_CTRL:  prdata <= {24'h000000, ctrl_q};
        `DTSL_ADDR_TRIG:  prdata <= {24'h000000, trig_q}; // [RULE1]
        `DTSL_ADDR_STAT:  prdata <= {24'h000000, af_q, bf_q,
                                     runf_q & ctrl_q[`DTSL_CTRL_ON], 1'b0, cnt_q}; // [RULE11]
        `DTSL_ADDR_FIFOH: prdata <= {24'h000000, ev_mode ? 8'h00 : fifo_word[15:8]}; // [RULE20]
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ### src/dtsl_defs.svh
`ifndef DTSL_DEFS_SVH
`define DTSL_DEFS_SVH
// Summary of operation
// RULE1: Trigger setup readable always, writable only while run request clear; bits 4,5 zero.
// RULE2: Qualify bit 7 set: A/B match triggers only when matched opcode executes.
// RULE3: Qualify bit clear: any access to compare address triggers at once.
// RULE4: Capture select bit 6: 0 circular fill until trigger, 1 trigger begins storage.
// RULE5: Event-only modes ignore capture select and always act as begin trace.
// RULE6: Mode 0000 A only, 0001 A or B, 0010 A then B.
// RULE7: Mode 0011 store on each B; 0100 after A store on each B.
// RULE8: Mode 0101 address A and data B; 0110 address A and data not B.
// RULE9: Mode 0111 inside range A..B; 1000 outside range.
// RULE10: Modes 1001 through 1111 give no trigger events.
// RULE11: Status register is read-only; writes change nothing.
// RULE12: Comparator A hit flag clears at run start, sets on A match.
// RULE13: Comparator B hit flag clears at run start, sets on B match.
// RULE14: While unit on, run-active flag mirrors run request, set by writing 1.
// RULE15: Run ends when FIFO fills in begin trace or on trigger in end trace.
// RULE16: Run also ends when software writes 0 to run request or unit enable.
// RULE17: Valid-word count clears at run start, holds 0..8 valid words at end.
// RULE18: Valid-word count does not change as FIFO words are read out.
// RULE19: Host tallies words read itself, starting from captured count.
// RULE20: Event-only modes store low byte only; high-byte port reads zero.
// RULE21: Writing 1 sets run request and flag; run completion clears it.
// RULE22: Trigger setup writes during a run are discarded.

// ****************************************
// Register byte addresses
// ****************************************
`define DTSL_ADDR_CTRL    12'h000
`define DTSL_ADDR_TRIG    12'h004
`define DTSL_ADDR_STAT    12'h008
`define DTSL_ADDR_FIFOH   12'h00C

// ****************************************
// Field positions
// ****************************************
`define DTSL_CTRL_ON      7
`define DTSL_CTRL_RUN     6
`define DTSL_TRIG_QUAL    7
`define DTSL_TRIG_BEGIN   6
`define DTSL_TRIG_MASK    8'hCF
`define DTSL_STAT_AF      7
`define DTSL_STAT_BF      6
`define DTSL_STAT_RUN     5

// ****************************************
// Reset values and sizes
// ****************************************
`define DTSL_CTRL_RST     8'h00
`define DTSL_TRIG_RST     8'h00
`define DTSL_FIFO_DEPTH   4'h8
`endif

// ### src/dtsl_pkg.sv
package dtsl_pkg;
  typedef enum logic [3:0] {
    DTSL_M_A_ONLY, DTSL_M_A_OR_B, DTSL_M_A_THEN_B, DTSL_M_EV_B,
    DTSL_M_A_THEN_EV_B, DTSL_M_A_AND_B, DTSL_M_A_AND_NOT_B,
    DTSL_M_INSIDE, DTSL_M_OUTSIDE
  } dtsl_mode_e;
  typedef enum logic [1:0] {DTSL_IDLE, DTSL_WAIT_A, DTSL_ARMED} dtsl_seq_e;
endpackage

// ### src/dtsl_cmp_if.sv
`timescale 1ns/1ps
interface dtsl_cmp_if;
  logic       match_a;
  logic       match_b;
  logic       exec_a;
  logic       exec_b;
  logic       qual_sel;
  logic       hit_a;
  logic       hit_b;
  modport qual (input match_a, match_b, exec_a, exec_b, qual_sel, output hit_a, hit_b);
  modport user (output match_a, match_b, exec_a, exec_b, qual_sel, input hit_a, hit_b);
endinterface

// ### src/dtsl_qualify.sv
`timescale 1ns/1ps
module dtsl_qualify
  import dtsl_pkg::*;
(
  // Comparator side
  dtsl_cmp_if.qual cmp
);
  // ****************************************
  // Tag or force qualification
  // ****************************************
  // Tag waits for execute strobe of the matched opcode
  assign cmp.hit_a = cmp.qual_sel ? (cmp.match_a & cmp.exec_a) : cmp.match_a; // [RULE2] [RULE3]
  assign cmp.hit_b = cmp.qual_sel ? (cmp.match_b & cmp.exec_b) : cmp.match_b; // [RULE2] [RULE3]
endmodule

// ### verif/dtsl_checker.sv
`timescale 1ns/1ps
module dtsl_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Run state
  input wire logic        trigger_event,
  input wire logic        fifo_store,
  input wire logic        run_active
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (rst);
  logic acc;
  logic wr_ctrl;
  assign acc     = psel && penable;
  assign wr_ctrl = acc && pwrite && paddr == 12'h000;
  sequence s_start; wr_ctrl && pwdata[7:6] == 2'b11 && !run_active; endsequence
  sequence s_calm; run_active && !wr_ctrl && !trigger_event && !fifo_store; endsequence
  property p_start; s_start |=> run_active; endproperty
  a_start: assert property (p_start) else $error("run did not start");
  property p_idle; !run_active && !(wr_ctrl && pwdata[7:6] == 2'b11) |=> !run_active; endproperty
  a_idle: assert property (p_idle) else $error("run started by itself");
  property p_stop_run; wr_ctrl && !pwdata[6] |=> !run_active; endproperty
  a_stop_run: assert property (p_stop_run) else $error("run bit clear kept run");
  property p_stop_on; wr_ctrl && !pwdata[7] |=> !run_active; endproperty
  a_stop_on: assert property (p_stop_on) else $error("unit off kept run");
  // Stores may close the run one cycle late, so the cycle after one is excused
  property p_hold; s_calm ##0 !$past(fifo_store) |=> run_active; endproperty
  a_hold: assert property (p_hold) else $error("run ended without cause");
  property p_trig; trigger_event |-> run_active; endproperty
  a_trig: assert property (p_trig) else $error("trigger while idle");
  property p_store; fifo_store |-> $past(run_active); endproperty
  a_store: assert property (p_store) else $error("store while idle");
  property p_trig_rd; acc && !pwrite && paddr == 12'h004 |-> prdata[5:4] == 2'b00 && !pslverr;
  endproperty
  a_trig_rd: assert property (p_trig_rd) else $error("setup read bad");
  property p_stat_rd; acc && !pwrite && paddr == 12'h008 |-> !prdata[4] && !pslverr; endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status read bad");
endmodule
bind dtsl_top dtsl_checker chk_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .trigger_event(trigger_event), .fifo_store(fifo_store), .run_active(run_active));

// ### verif/dtsl_fifo_model.sv
`timescale 1ns/1ps
module dtsl_fifo_model (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Store side
  input wire logic        fifo_store,
  input wire logic [15:0] fifo_store_data,
  input wire logic        run_active,
  // Host side
  output logic     [15:0] fifo_word,
  output logic     [3:0]  words_held_q
);
  // ****************************************
  // Storage and host tally
  // ****************************************
  logic [15:0] mem_q [8];
  logic        run_seen_q;
  // Empty head shows a busy pattern, never a stale zero
  assign fifo_word = (words_held_q == 4'h0) ? 16'hA55A : mem_q[0];
  // Tally restarts with each run, as the captured count does
  always_ff @(posedge mclk) begin
    if (rst) begin
      run_seen_q <= 1'b0;
    end else begin
      run_seen_q <= run_active;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      words_held_q <= 4'h0;
    end else if (run_active && !run_seen_q) begin
      words_held_q <= 4'h0;
    end else if (fifo_store && words_held_q != 4'h8) begin
      mem_q[words_held_q[2:0]] <= fifo_store_data;
      words_held_q             <= words_held_q + 4'h1;
    end
  end
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb
  import dtsl_pkg::*;
;
  // ****************************************
  // Harness
  // ****************************************
  logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic        ca = 0, cb = 0, ea = 0, eb = 0, lt = 0, gt = 0, cv = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] cap = 16'h5A00, fword, sdata;
  logic [3:0]  held;
  logic        pready, pslverr, fstore, trig, run, tg, err;
  int          num_errors = 0, samples_checked = 0;
  always #2 mclk = ~mclk;
  dtsl_top dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_a_match(ca), .cmp_b_match(cb), .cmp_a_exec(ea), .cmp_b_exec(eb), .addr_lt_a(lt),
    .addr_gt_b(gt), .capture_data(cap), .capture_valid(cv), .fifo_word(fword),
    .fifo_store(fstore), .fifo_store_data(sdata), .trigger_event(trig), .run_active(run));
  dtsl_fifo_model fifo_u (.mclk(mclk), .rst(rst), .fifo_store(fstore), .fifo_store_data(sdata),
    .run_active(run), .fifo_word(fword), .words_held_q(held));
  task automatic test_done;
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin num_errors++; test_done(); end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge mclk);
  endtask
  task automatic hit(input logic a, input logic b, input logic e);
    ca <= a; cb <= b; ea <= e; eb <= e; cv <= a | b; cap <= cap + 16'h0101;
    #1 tg = trig;
    @(posedge mclk);
    ca <= 0; cb <= 0; ea <= 0; eb <= 0; cv <= 0;
    @(posedge mclk);
  endtask
  task automatic t_regs;
    apb(1, 12'h004, 32'hFF); apb(0, 12'h004, 0); `CHK(rd, 32'hCF)
    apb(1, 12'h008, 32'hFF); apb(0, 12'h008, 0); `CHK(rd, 32'h0)
    apb(0, 12'h010, 0); `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
  endtask
  task automatic t_lock;
    apb(1, 12'h004, 32'h41); apb(1, 12'h000, 32'hC0); apb(0, 12'h008, 0);
    `CHK(run, 1'b1)
    `CHK(rd[5], 1'b1)
    `CHK(rd[7:6], 2'b00)
    `CHK(rd[3:0], 4'h0)
    apb(1, 12'h004, 32'h00); apb(0, 12'h004, 0); `CHK(rd[7:0], 8'h41)
    apb(1, 12'h000, 32'h80); apb(0, 12'h008, 0); `CHK(rd[5], 1'b0)
  endtask
  // One A and B hit at once: only modes needing no earlier A or no mismatch fire
  task automatic t_modes;
    logic [15:0] fire, ends;
    fire = 16'h00AB;
    ends = 16'h00A3;
    for (int m = 0; m < 16; m++) begin
      apb(1, 12'h004, m); apb(1, 12'h000, 32'hC0); hit(1, 1, 0);
      `CHK(tg, fire[m])
      apb(0, 12'h008, 0); `CHK(rd[5], ~ends[m])
      `CHK(rd[7:6], 2'b11)
      apb(1, 12'h000, 32'h00);
    end
  endtask
  task automatic t_tag;
    logic [15:0] want;
    apb(1, 12'h004, 32'h80); apb(1, 12'h000, 32'hC0);
    want = cap + 16'h0101;
    hit(1, 0, 0); `CHK(tg, 1'b0)
    hit(1, 0, 1); `CHK(tg, 1'b1)
    apb(1, 12'h000, 32'h00);
    apb(0, 12'h00C, 0); `CHK(rd[7:0], want[15:8])
  endtask
  // A alone arms the sequenced modes; range modes read the bound compares
  task automatic t_seq;
    apb(1, 12'h004, 32'h02); apb(1, 12'h000, 32'hC0);
    hit(1, 0, 0); `CHK(tg, 1'b0)
    hit(0, 1, 0); `CHK(tg, 1'b1)
    apb(1, 12'h004, 32'h04); apb(1, 12'h000, 32'hC0);
    hit(0, 1, 0); `CHK(tg, 1'b0)
    hit(1, 0, 0); hit(0, 1, 0); `CHK(tg, 1'b1)
    hit(0, 1, 0); `CHK(tg, 1'b1)
    apb(1, 12'h000, 32'h00);
    apb(1, 12'h004, 32'h06); apb(1, 12'h000, 32'hC0);
    hit(1, 0, 0); `CHK(tg, 1'b1)
    apb(1, 12'h004, 32'h08); apb(1, 12'h000, 32'hC0); lt <= 1;
    hit(1, 0, 0); `CHK(tg, 1'b1)
    apb(1, 12'h004, 32'h07); apb(1, 12'h000, 32'hC0);
    hit(1, 0, 0); `CHK(tg, 1'b0)
    lt <= 0; apb(1, 12'h000, 32'h00);
  endtask
  task automatic t_count;
    logic [15:0] want;
    apb(1, 12'h004, 32'h03); apb(1, 12'h000, 32'hC0);
    want = cap + 16'h0101;
    repeat (10) hit(0, 1, 0);
    apb(0, 12'h008, 0); `CHK(rd[3:0], 4'h8)
    `CHK(rd[5], 1'b0)
    `CHK(held, 4'h8)
    `CHK(fword[15:8], 8'h00)
    `CHK(fword[7:0], want[7:0])
    apb(0, 12'h00C, 0); `CHK(rd, 32'h0)
    apb(0, 12'h008, 0); `CHK(rd[3:0], 4'h8)
  endtask
  // Reset in mid-run must drop the run and every flag
  task automatic t_reset;
    apb(1, 12'h000, 32'hC0); hit(1, 1, 0);
    rst <= 1;
    repeat (2) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    `CHK(run, 1'b0)
    apb(0, 12'h008, 0); `CHK(rd, 32'h0)
    apb(0, 12'h004, 0); `CHK(rd, 32'h0)
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 0;
    t_regs(); t_lock(); t_modes(); t_tag(); t_seq(); t_count(); t_reset();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    test_done();
  end
endmodule
